// ===== verilog/rtcc_cfg.svh
// Address map, reset values and decode limits of the clock/calendar serial port.
// Assumes an include by bare name from design files only; definitions only.
`ifndef RTCC_CFG_SVH
`define RTCC_CFG_SVH

`define RTCC_TIME_LAST 8'h06
`define RTCC_CFG_LAST 8'h09
`define RTCC_ALM0_LAST 8'h10
`define RTCC_ALM1_LAST 8'h17
`define RTCC_REG_LAST 8'h1F
`define RTCC_SRAM_LAST 8'h5F
`define RTCC_MEM_DEPTH 96
`define RTCC_CTRL_ADDR 7
`define RTCC_CTRL_RST 8'h80
`define RTCC_ONE_RST 8'h01
`define RTCC_ONE_MASK 32'h00F1E078
`define RTCC_BIT_LAST 3'h7

`endif

// ===== verilog/rtcc_pkg.sv
// Types shared by the serial port and its write buffer.
// Assumes nothing beyond a SystemVerilog compiler.
package rtcc_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CTRL = 4'h1,
		ST_CACK = 4'h3,
		ST_ADDR = 4'h2,
		ST_AACK = 4'h6,
		ST_WDATA = 4'h7,
		ST_WACK = 4'h5,
		ST_RDATA = 4'h4,
		ST_RACK = 4'hC
	} state_t;

	typedef enum logic [2:0] {
		RG_TIME = 3'h0,
		RG_CONFIG = 3'h1,
		RG_ALARM0 = 3'h2,
		RG_ALARM1 = 3'h3,
		RG_STAMP = 3'h4,
		RG_SRAM = 3'h5
	} region_t;

	typedef struct packed {
		region_t region;
		logic [6:0] addr;
		logic [7:0] data;
	} wr_event_t;

endpackage

// ===== verilog/rtcc_write_buffer.sv
// Two-entry buffer for write events leaving the serial port.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module rtcc_write_buffer import rtcc_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wr_event_t in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output wr_event_t out_data_out
);

	logic tail_valid;
	wr_event_t tail;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;

	// Ready from the tail alone keeps the path from receiver to sender short
	assign in_ready_out = ~tail_valid;

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
			tail_valid <= 1'b0;
			tail <= '0;
		end else if (pop) begin
			out_valid_out <= tail_valid | push;
			out_data_out <= tail_valid ? tail : in_data_in;
			tail_valid <= tail_valid & push;
			tail <= in_data_in;
		end else if (push && !out_valid_out) begin
			out_valid_out <= 1'b1;
			out_data_out <= in_data_in;
		end else if (push) begin
			tail_valid <= 1'b1;
			tail <= in_data_in;
		end
	end

endmodule

// ===== verilog/rtcc_serial_slave_port.sv
// Two-wire slave port of a clock/calendar: control byte, address, register and SRAM access.
// Assumes scl_in and sda_in already synchronous to sys_clk_in and sampled well above bus rate.
`timescale 1ns/1ns
`include "rtcc_cfg.svh"

// What this block does
// - Data falling while clock high is a start; device recognises it.
// - Data rising while clock high is a stop; device recognises it.
// - One bit per clock pulse, sampled at clock rising edge.
// - Receiver acknowledges each byte on an extra ninth clock pulse.
// - Acknowledge holds data low through the whole high phase.
// - Master not acknowledging a read byte makes the device release data.
// - First seven bits must match the device code before acknowledging.
// - Eighth control bit picks direction: one reads, zero writes.
// - Address byte follows control byte, most significant bit first.
// - Registers sit low, 64 SRAM bytes directly above in one space.
// - Out-of-range address gets no acknowledge; unimplemented locations read zero.
// - Time and date writes are stored unchecked.
// - Lowest seven addresses are readable and writable time and date.
// - Next three addresses decode to configuration and calibration.
// - Alarm-zero block holds alarm-zero match, polarity and compare settings.
// - Next seven addresses decode to alarm-one registers.
// - Top eight register addresses decode to power-fail timestamps.
module rtcc_serial_slave_port import rtcc_pkg::*; #(
	parameter logic [6:0] DEV_CODE = 7'h2A // Arbitrary value
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n_out,
	output logic wr_valid_out,
	output wr_event_t wr_event_out,
	input wire logic wr_ready_in
);

	state_t state;
	state_t next_state;
	logic scl_q;
	logic sda_q;
	logic [2:0] bit_cnt;
	logic byte_full;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [6:0] ptr;
	logic rw;
	logic [7:0] mem [0:`RTCC_MEM_DEPTH-1];
	logic buf_in_ready;
	wr_event_t buf_in_data;
	region_t region;

	function automatic logic [7:0] reset_byte(input int idx);
		logic [31:0] mask;
		mask = `RTCC_ONE_MASK;
		if (idx == `RTCC_CTRL_ADDR) begin
			reset_byte = `RTCC_CTRL_RST;
		end else if (idx < 32 && mask[idx]) begin
			reset_byte = `RTCC_ONE_RST;
		end else begin
			reset_byte = 8'h00;
		end
	endfunction

	// Bus condition decode from the previous and present samples
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
	wire rx_state = (state == ST_CTRL) | (state == ST_ADDR) | (state == ST_WDATA);
	wire count_state = rx_state | (state == ST_RDATA);
	wire byte_end = byte_full & scl_fall;
	wire ctrl_match = (rx_shift[7:1] == DEV_CODE);
	wire addr_ok = (rx_shift <= `RTCC_SRAM_LAST);
	wire [7:0] ptr_wide = {1'b0, ptr};
	wire ptr_ok = (ptr_wide <= `RTCC_SRAM_LAST);
	wire wr_ok = ptr_ok & buf_in_ready;
	wire [6:0] next_ptr = ptr + 7'h01;
	wire [7:0] rd_byte = ptr_ok ? mem[ptr] : 8'h00;
	wire state_change = (next_state != state);
	wire enter_rdata = (next_state == ST_RDATA) & state_change;
	wire shift_tx = (state == ST_RDATA) & scl_fall & ~byte_full & ~state_change;
	wire enter_ack = state_change & ((next_state == ST_CACK) | (next_state == ST_AACK) |
		(next_state == ST_WACK));
	wire store_byte = (state == ST_WDATA) & byte_end & wr_ok & ~start_cond & ~stop_cond;
	wire is_ack_state = (state == ST_CACK) | (state == ST_AACK) | (state == ST_WACK);

	// Block that the pointer falls in, handed on with every write
	assign region = (ptr_wide <= `RTCC_TIME_LAST) ? RG_TIME :
		(ptr_wide <= `RTCC_CFG_LAST) ? RG_CONFIG :
		(ptr_wide <= `RTCC_ALM0_LAST) ? RG_ALARM0 :
		(ptr_wide <= `RTCC_ALM1_LAST) ? RG_ALARM1 :
		(ptr_wide <= `RTCC_REG_LAST) ? RG_STAMP : RG_SRAM;
	assign buf_in_data = '{region: region, addr: ptr, data: rx_shift};

	// Pull-down decision; released on every other transition
	wire next_pull = enter_rdata ? ~rd_byte[7] :
		shift_tx ? ~tx_shift[6] :
		enter_ack ? 1'b1 :
		state_change ? 1'b0 : ~sda_oe_n_out;

	always_comb begin
		next_state = state;
		if (stop_cond) begin
			next_state = ST_IDLE;
		end else if (start_cond) begin
			next_state = ST_CTRL;
		end else begin
			case (state)
				ST_CTRL: if (byte_end) next_state = ctrl_match ? ST_CACK : ST_IDLE;
				ST_CACK: if (scl_fall) next_state = rw ? ST_RDATA : ST_ADDR;
				ST_ADDR: if (byte_end) next_state = addr_ok ? ST_AACK : ST_IDLE;
				ST_AACK: if (scl_fall) next_state = ST_WDATA;
				ST_WDATA: if (byte_end) next_state = wr_ok ? ST_WACK : ST_IDLE;
				ST_WACK: if (scl_fall) next_state = ST_WDATA;
				ST_RDATA: if (byte_end) next_state = ST_RACK;
				ST_RACK: begin
					if (scl_rise && sda_in) begin
						next_state = ST_IDLE;
					end else if (scl_fall) begin
						next_state = ST_RDATA;
					end
				end
				ST_IDLE: next_state = ST_IDLE;
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state <= ST_IDLE;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			state <= next_state;
		end
	end

	// Bit counting restarts on every state change, so a new byte always starts clean
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bit_cnt <= 3'h0;
			byte_full <= 1'b0;
		end else if (state_change) begin
			bit_cnt <= 3'h0;
			byte_full <= 1'b0;
		end else if (scl_rise && count_state) begin
			bit_cnt <= bit_cnt + 3'h1;
			byte_full <= (bit_cnt == `RTCC_BIT_LAST);
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rx_shift <= 8'h00;
		end else if (scl_rise && rx_state) begin
			rx_shift <= {rx_shift[6:0], sda_in};
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rw <= 1'b0;
		end else if (state == ST_CTRL && byte_end) begin
			rw <= rx_shift[0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_shift <= 8'h00;
		end else if (enter_rdata) begin
			tx_shift <= rd_byte;
		end else if (shift_tx) begin
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	// Pointer survives a stop, so a later read continues from the last address
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ptr <= 7'h00;
		end else if (state == ST_ADDR && next_state == ST_AACK) begin
			ptr <= rx_shift[6:0];
		end else if (store_byte || enter_rdata) begin
			ptr <= next_ptr;
		end
	end

	// No range check on stored values: the timekeeper sees exactly what was sent
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < `RTCC_MEM_DEPTH; i++) begin
				mem[i] <= reset_byte(i);
			end
		end else if (store_byte) begin
			mem[ptr] <= rx_shift;
		end
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sda_oe_n_out <= 1'b1;
			sda_out <= 1'b1;
		end else begin
			sda_oe_n_out <= ~next_pull;
			sda_out <= ~next_pull;
		end
	end

	// A full buffer turns the byte into a no-acknowledge rather than losing it
	rtcc_write_buffer u_wbuf (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(store_byte),
		.in_ready_out(buf_in_ready),
		.in_data_in(buf_in_data),
		.out_valid_out(wr_valid_out),
		.out_ready_in(wr_ready_in),
		.out_data_out(wr_event_out)
	);

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!resetn_in);

	property p_start_ctrl;
		start_cond && !stop_cond |=> state == ST_CTRL && sda_oe_n_out;
	endproperty
	a_start_ctrl: assert property (p_start_ctrl) else $error("start not taken");

	property p_stop_idle;
		stop_cond |=> state == ST_IDLE && sda_oe_n_out;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

	property p_ctrl_ack;
		state == ST_CTRL && byte_end && ctrl_match && !start_cond && !stop_cond
			|=> state == ST_CACK && !sda_oe_n_out;
	endproperty
	a_ctrl_ack: assert property (p_ctrl_ack) else $error("matching code not acked");

	property p_ctrl_nack;
		state == ST_CTRL && byte_end && !ctrl_match && !start_cond && !stop_cond
			|=> state == ST_IDLE && sda_oe_n_out;
	endproperty
	a_ctrl_nack: assert property (p_ctrl_nack) else $error("wrong code acked");

	property p_addr_nack;
		state == ST_ADDR && byte_end && !addr_ok && !start_cond && !stop_cond
			|=> state == ST_IDLE && sda_oe_n_out;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("bad address acked");

	property p_ack_hold;
		is_ack_state && !sda_oe_n_out && scl_rise |=> !sda_oe_n_out;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped in high phase");

	property p_read_nack;
		state == ST_RACK && scl_rise && sda_in && !start_cond && !stop_cond
			|=> state == ST_IDLE ##1 sda_oe_n_out;
	endproperty
	a_read_nack: assert property (p_read_nack) else $error("line held after nack");

	property p_ptr_step;
		store_byte |=> ptr == $past(next_ptr);
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced");

	property p_write_ack;
		store_byte |=> state == ST_WACK && !sda_oe_n_out && mem[$past(ptr)] == $past(rx_shift);
	endproperty
	a_write_ack: assert property (p_write_ack) else $error("write byte not stored");

	property p_dir_read;
		state == ST_CACK && scl_fall && rw && !start_cond && !stop_cond
			|=> state == ST_RDATA && sda_oe_n_out == $past(rd_byte[7]);
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("read not started");

	property p_bit_capture;
		scl_rise && rx_state |=> rx_shift[0] == $past(sda_in);
	endproperty
	a_bit_capture: assert property (p_bit_capture) else $error("bit not captured");

	property p_addr_load;
		state == ST_ADDR && byte_end && addr_ok && !start_cond && !stop_cond
			|=> state == ST_AACK && !sda_oe_n_out && ptr == $past(rx_shift[6:0]);
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("address not taken");

	property p_ack_release;
		is_ack_state && scl_fall && !start_cond && !stop_cond && !(state == ST_CACK && rw)
			|=> sda_oe_n_out;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack held too long");

	property p_write_refuse;
		state == ST_WDATA && byte_end && !wr_ok && !start_cond && !stop_cond
			|=> state == ST_IDLE && sda_oe_n_out;
	endproperty
	a_write_refuse: assert property (p_write_refuse) else $error("refused byte acked");

	property p_read_step;
		enter_rdata |=> ptr == $past(next_ptr) && tx_shift == $past(rd_byte);
	endproperty
	a_read_step: assert property (p_read_step) else $error("read pointer not advanced");

	property p_read_beyond;
		enter_rdata && !ptr_ok |=> !sda_oe_n_out && tx_shift == 8'h00;
	endproperty
	a_read_beyond: assert property (p_read_beyond) else $error("unused byte not zero");

	property p_tx_bit;
		shift_tx |=> sda_oe_n_out == $past(tx_shift[6]);
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("read bit wrong");

	property p_master_ack_slot;
		state == ST_RDATA && byte_end && !start_cond && !stop_cond
			|=> state == ST_RACK && sda_oe_n_out;
	endproperty
	a_master_ack_slot: assert property (p_master_ack_slot) else $error("ack slot driven");

	// A stalled consumer must see the same word until it takes it
	property p_buf_hold;
		wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_event_out);
	endproperty
	a_buf_hold: assert property (p_buf_hold) else $error("buffered word lost");

	c_write_burst: cover property (store_byte ##[1:300] store_byte);
	c_read_end: cover property (state == ST_RACK && scl_rise && sda_in);
	c_addr_refused: cover property (state == ST_ADDR && byte_end && !addr_ok);
	c_buffer_stall: cover property (state == ST_WDATA && byte_end && ptr_ok && !buf_in_ready);
	c_read_beyond: cover property (enter_rdata && !ptr_ok);

endmodule

// ===== sim/rtcc_i2c_master_model.sv
// Bus master model driving serial clock and data of the slave port.
// Assumes the data wire has a pull-up and is resolved by the bench.
`timescale 1ns/1ns
module rtcc_i2c_master_model (
	input wire logic sys_clk_in,
	input wire logic sda_wire_in,
	output logic scl_out,
	output logic sda_out
);
	localparam int HALF = 4;
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic wait_half();
		repeat (HALF) @(posedge sys_clk_in);
	endtask
	// Also serves as repeated start from clock low
	task automatic start();
		sda_out <= 1'b1;
		wait_half();
		scl_out <= 1'b1;
		wait_half();
		sda_out <= 1'b0;
		wait_half();
		scl_out <= 1'b0;
	endtask
	task automatic stop();
		wait_half();
		sda_out <= 1'b0;
		wait_half();
		scl_out <= 1'b1;
		wait_half();
		sda_out <= 1'b1;
		wait_half();
	endtask
	task automatic bit_io(input logic b, output logic r);
		wait_half();
		sda_out <= b;
		wait_half();
		scl_out <= 1'b1;
		wait_half();
		r = sda_wire_in;
		scl_out <= 1'b0;
	endtask
	// Ninth pulse carries the acknowledge, low means acknowledged
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ack_in, ack);
	endtask
endmodule

// ===== sim/rtcc_serial_slave_port_tb_top.sv
// Testbench of the serial slave port, with a bus master model on the far side.
// Sets the design's device code itself and assumes the master model beside it.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
	end \
end
module rtcc_serial_slave_port_tb_top;
	import rtcc_pkg::*;
	localparam logic [6:0] DEV = 7'h2A; // Arbitrary value
	localparam logic [7:0] CW = {DEV, 1'b0};
	localparam logic [7:0] CR = {DEV, 1'b1};
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic wr_ready = 1'b0;
	logic scl, msda, sda_out, sda_oe_n, wr_valid, a, sda_wire;
	logic [7:0] q;
	wr_event_t wr_event;
	int mismatches = 0;
	int n_tests = 0;
	// Open drain with pull-up: any party pulling low wins
	assign sda_wire = msda & (sda_oe_n | sda_out);
	rtcc_i2c_master_model i_rtcc_i2c_master_model (.sys_clk_in(sys_clk_in),
		.sda_wire_in(sda_wire), .scl_out(scl), .sda_out(msda));
	rtcc_serial_slave_port #(.DEV_CODE(DEV)) i_rtcc_serial_slave_port (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_out), .sda_oe_n_out(sda_oe_n), .wr_valid_out(wr_valid),
		.wr_event_out(wr_event), .wr_ready_in(wr_ready));
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	task automatic end_sim();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
		i_rtcc_i2c_master_model.byte_io(d, 1'b1, q, a);
		`CHK("write ack", exp_ack, a)
	endtask
	task automatic wr_hdr(input logic [7:0] addr);
		i_rtcc_i2c_master_model.start();
		wr_byte(CW, 1'b0);
		wr_byte(addr, 1'b0);
	endtask
	// Pops one event from the buffer, consumer stalled otherwise
	task automatic take_event(input wr_event_t e);
		int n;
		n = 0;
		while (wr_valid !== 1'b1 && n < 50) begin
			@(posedge sys_clk_in);
			n++;
		end
		`CHK("event valid", 1'b1, wr_valid)
		`CHK("event", e, wr_event)
		wr_ready <= 1'b1;
		@(posedge sys_clk_in);
		wr_ready <= 1'b0;
		// Head shows the next entry only one edge after the pop
		@(posedge sys_clk_in);
	endtask
	task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp[$]);
		wr_hdr(addr);
		i_rtcc_i2c_master_model.start();
		wr_byte(CR, 1'b0);
		foreach (exp[i]) begin
			i_rtcc_i2c_master_model.byte_io(8'hFF, 1'(i == exp.size() - 1), q, a);
			`CHK("read data", exp[i], q)
		end
		i_rtcc_i2c_master_model.stop();
		`CHK("line released", 1'b1, sda_oe_n)
	endtask
	// One write per region, time byte deliberately not a valid count
	task automatic t_regions();
		logic [7:0] ad[6] = '{8'h00, 8'h07, 8'h0A, 8'h11, 8'h18, 8'h20};
		for (int i = 0; i < 6; i++) begin
			wr_hdr(ad[i]);
			wr_byte(8'hF8 + 8'(i), 1'b0);
			i_rtcc_i2c_master_model.stop();
			take_event('{region_t'(i), ad[i][6:0], 8'hF8 + 8'(i)});
		end
		rd_check(8'h00, '{8'hF8, 8'h00, 8'h00, 8'h01});
	endtask
	task automatic t_sram_edge();
		wr_hdr(8'h5E);
		wr_byte(8'h5A, 1'b0);
		wr_byte(8'hA5, 1'b0);
		wr_byte(8'h77, 1'b1);
		i_rtcc_i2c_master_model.stop();
		take_event('{RG_SRAM, 7'h5E, 8'h5A});
		take_event('{RG_SRAM, 7'h5F, 8'hA5});
		rd_check(8'h5E, '{8'h5A, 8'hA5, 8'h00});
	endtask
	task automatic t_refuse();
		i_rtcc_i2c_master_model.start();
		wr_byte({DEV ^ 7'h01, 1'b0}, 1'b1);
		i_rtcc_i2c_master_model.start();
		wr_byte(CW, 1'b0);
		wr_byte(8'h60, 1'b1);
		i_rtcc_i2c_master_model.stop();
		`CHK("no event", 1'b0, wr_valid)
	endtask
	// Consumer stalls, so the third byte finds both entries taken
	task automatic t_full();
		wr_hdr(8'h20);
		wr_byte(8'h11, 1'b0);
		wr_byte(8'h22, 1'b0);
		wr_byte(8'h33, 1'b1);
		i_rtcc_i2c_master_model.stop();
		take_event('{RG_SRAM, 7'h20, 8'h11});
		take_event('{RG_SRAM, 7'h21, 8'h22});
		@(posedge sys_clk_in);
		`CHK("buffer empty", 1'b0, wr_valid)
	endtask
	initial begin
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		t_regions();
		t_sram_edge();
		t_refuse();
		t_full();
		end_sim();
	end
	// Whole run is near 5100 clocks
	initial begin
		#500000;
		mismatches++;
		end_sim();
	end
endmodule
